// File: ira_pkg.sv
// constants and types shared by the two-wire register access host
package ira_pkg;

  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          BIT_PERIOD_NS  = 2500;
  localparam int          QUARTER_NS     = BIT_PERIOD_NS / 4;
  localparam int          QUARTER_CYC    = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          XFER_WAIT_US   = 128;
  localparam int          XFER_WAIT_CYC  = (XFER_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 16;

  localparam logic [4:0]  SLAVE_ADDR_BASE = 5'h17;
  localparam logic        DIR_WRITE       = 1'h0;
  localparam logic        DIR_READ        = 1'h1;
  localparam logic        BIT_ACK         = 1'h0;
  localparam logic [7:0]  WAIT_REG_LAST   = 8'h8f;
  localparam logic [7:0]  SUB_STEP        = 8'h01;
  localparam logic [7:0]  LEN_ONE         = 8'h01;
  localparam logic [7:0]  LEN_ZERO        = 8'h00;
  localparam logic [3:0]  ACK_SLOT        = 4'h8;
  localparam logic [3:0]  BIT_FIRST       = 4'h0;
  localparam logic [3:0]  BIT_STEP        = 4'h1;
  localparam logic [1:0]  QTR_SET_DATA    = 2'h1;
  localparam logic [1:0]  QTR_SCL_UP      = 2'h2;
  localparam logic [1:0]  QTR_LAST        = 2'h3;
  localparam logic [1:0]  QTR_STEP        = 2'h1;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          DATA_W          = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_FETCH,
    ST_WAIT,
    ST_STOP,
    ST_DONE
  } ira_state_t;

  typedef enum logic [2:0] {
    K_ADDR_W,
    K_SUB,
    K_WDATA,
    K_ADDR_R,
    K_RDATA
  } ira_kind_t;

endpackage : ira_pkg

// File: ira_fifo_if.sv
// valid/ready carrier between the host engine and its write data fifo
`timescale 1ns/1ns
interface ira_fifo_if #(
  parameter int W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );
endinterface : ira_fifo_if

// File: ira_fifo.sv
// small first-word-fall-through fifo with registered flags and output word
`timescale 1ns/1ns
module ira_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  ira_fifo_if.fifo  port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          in_ready_q;
  logic          out_valid_q;
  logic [W-1:0]  out_data_q;
  logic          push;
  logic          pop;
  logic [AW-1:0] rd_next;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign push = port.in_valid && in_ready_q;
  assign pop  = out_valid_q && port.out_ready;
  assign rd_next = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= port.in_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      cnt_q       <= '0;
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      rd_ptr_q    <= rd_next;
      cnt_q       <= cnt_d;
      in_ready_q  <= (cnt_d != CNT_FULL);
      out_valid_q <= (cnt_d != '0);
      // a word written into the slot that becomes the head is forwarded so the head is never stale
      if (push && (wr_ptr_q == rd_next)) begin
        out_data_q <= port.in_data;
      end else begin
        out_data_q <= mem_q[rd_next];
      end
    end
  end

  assign port.in_ready  = in_ready_q;
  assign port.out_valid = out_valid_q;
  assign port.out_data  = out_data_q;

endmodule : ira_fifo

// File: ira_host.sv
// two-wire bus master that writes and reads the decoder's registers
// What the document requires
// RULE_01: write opens with start, seven-bit address msb first, direction bit zero.
// RULE_02: after address ack, send one sub-address byte then data bytes, msb first.
// RULE_03: device acknowledges address, sub-address and every written data byte.
// RULE_04: end a write with stop after the last data byte is acknowledged.
// RULE_05: read begins by writing address with direction zero and the sub-address.
// RULE_06: in the read address phase stop right after the sub-address ack.
// RULE_07: read data phase uses a new start and address with direction one.
// RULE_08: device returns register bytes msb first while the master keeps acknowledging.
// RULE_09: master acknowledges every read byte except the last wanted one.
// RULE_10: after the last read byte, not-acknowledge then stop.
// RULE_11: device holds the clock low for a variable time when busy.
// RULE_12: a master not watching the clock inserts the maximum delay always; code waits only when the last sub-address is 00h-8Fh.
// RULE_13: unwatched clock: wait 128 us after final ack, before stop, for 00h-8Fh.
// RULE_14: device address comes from two select straps, four choices.
// RULE_15: writes go to every core whose bit is set at sub-address FE.
// RULE_16: reads are answered by the lowest set core bit at sub-address FF.
// RULE_17: device advances its sub-address after every transferred data byte.
// RULE_18: device does not acknowledge a non-matching slave address.
`timescale 1ns/1ns
module ira_host #(
  parameter int WAIT_CYC = ira_pkg::XFER_WAIT_CYC,
  parameter int DEPTH    = ira_pkg::FIFO_DEPTH
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic [7:0] cmd_sub_i,
  input  wire logic [7:0] cmd_len_i,
  input  wire logic       slave_addr_select_low_i,
  input  wire logic       slave_addr_select_high_i,
  input  wire logic       monitor_scl_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_valid_i,
  output logic            wr_ready_o,
  output logic [7:0]      rd_data_o,
  output logic            rd_valid_o,
  output logic            done_o,
  output logic            nack_o,
  output logic            busy_o,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o
);
  localparam logic [ira_pkg::CNT_W-1:0] QTR_END =
    ira_pkg::CNT_W'(ira_pkg::QUARTER_CYC - 1);
  localparam logic [ira_pkg::CNT_W-1:0] WAIT_END = ira_pkg::CNT_W'(WAIT_CYC - 1);

  ira_pkg::ira_state_t     state_q;
  ira_pkg::ira_kind_t      kind_q;
  logic [ira_pkg::CNT_W-1:0] cnt_q;
  logic [1:0]              qtr_q;
  logic [3:0]              bit_q;
  logic [7:0]              sh_q;
  logic [7:0]              sub_q;
  logic [7:0]              rem_q;
  logic                    read_q;
  logic                    pend_q;
  logic                    ack_q;
  logic                    err_q;
  logic                    cmd_ready_q;
  logic [7:0]              rd_data_q;
  logic                    rd_valid_q;
  logic                    done_q;
  logic                    busy_q;
  logic                    scl_oe_q;
  logic                    sda_oe_q;
  logic                    scl_low_d;
  logic                    sda_low_d;
  logic                    scl_s1_q;
  logic                    scl_s2_q;
  logic                    sda_s1_q;
  logic                    sda_s2_q;
  logic                    stretch;
  logic                    tick;
  logic                    wait_end;
  logic                    last_byte;
  logic                    need_wait;
  logic                    dev_nack;
  logic [6:0]              slave_addr;

  ira_fifo_if #(.W(ira_pkg::DATA_W)) fif ();

  ira_fifo #(
    .W     (ira_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .port    (fif)
  );

  assign fif.in_valid  = wr_valid_i;
  assign fif.in_data   = wr_data_i;
  assign fif.out_ready = (state_q == ira_pkg::ST_FETCH);

  function automatic logic is_tx(input ira_pkg::ira_kind_t k);
    is_tx = (k != ira_pkg::K_RDATA);
  endfunction : is_tx

  // the device decodes its address from the two straps
  assign slave_addr = {ira_pkg::SLAVE_ADDR_BASE, slave_addr_select_high_i,
                       slave_addr_select_low_i}; // RULE_14

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  // a released clock that still reads low means the device is holding it
  assign stretch = monitor_scl_i && (qtr_q == ira_pkg::QTR_SCL_UP) && !scl_s2_q &&
                   ((state_q == ira_pkg::ST_BIT) || (state_q == ira_pkg::ST_STOP)); // RULE_11
  assign tick = (state_q != ira_pkg::ST_WAIT) && (cnt_q == QTR_END) && !stretch;
  assign wait_end = (state_q == ira_pkg::ST_WAIT) && (cnt_q == WAIT_END);
  assign last_byte = (rem_q == ira_pkg::LEN_ONE);
  assign dev_nack = is_tx(kind_q) && (ack_q != ira_pkg::BIT_ACK); // RULE_03 RULE_18
  // without clock monitoring the longest wait is spent when the last sub-address is 00h-8Fh
  assign need_wait = !monitor_scl_i && (sub_q <= ira_pkg::WAIT_REG_LAST); // RULE_12 RULE_13

  always_ff @(posedge clock_i) begin
    if (rst_i || (state_q == ira_pkg::ST_IDLE) || (state_q == ira_pkg::ST_FETCH) ||
        (state_q == ira_pkg::ST_DONE)) begin
      cnt_q <= '0;
    end else if (tick || wait_end) begin
      cnt_q <= '0;
    end else if (!stretch) begin
      cnt_q <= cnt_q + ira_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || (state_q == ira_pkg::ST_IDLE) || (state_q == ira_pkg::ST_FETCH) ||
        (state_q == ira_pkg::ST_DONE)) begin
      qtr_q <= '0;
    end else if (tick) begin
      qtr_q <= qtr_q + ira_pkg::QTR_STEP;
    end
  end

  // within a bit, data only moves in the second quarter, well after the clock has fallen
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = sda_oe_q;
    unique case (state_q)
      ira_pkg::ST_IDLE,
      ira_pkg::ST_DONE: begin
        sda_low_d = 1'b0;
      end
      ira_pkg::ST_START: begin
        sda_low_d = (qtr_q == ira_pkg::QTR_LAST);
      end
      ira_pkg::ST_BIT: begin
        scl_low_d = (qtr_q < ira_pkg::QTR_SCL_UP);
        if (qtr_q == ira_pkg::QTR_SET_DATA) begin
          if (bit_q != ira_pkg::ACK_SLOT) begin
            sda_low_d = is_tx(kind_q) && !sh_q[7]; // RULE_01 RULE_02 RULE_07
          end else begin
            sda_low_d = !is_tx(kind_q) && !last_byte; // RULE_09 RULE_10
          end
        end
      end
      ira_pkg::ST_FETCH,
      ira_pkg::ST_WAIT: begin
        scl_low_d = 1'b1;
      end
      ira_pkg::ST_STOP: begin
        scl_low_d = (qtr_q < ira_pkg::QTR_SCL_UP);
        if (qtr_q != '0) begin
          sda_low_d = (qtr_q != ira_pkg::QTR_LAST);
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_low_d;
      sda_oe_q <= sda_low_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q     <= ira_pkg::ST_IDLE;
      kind_q      <= ira_pkg::K_ADDR_W;
      bit_q       <= ira_pkg::BIT_FIRST;
      sh_q        <= '0;
      sub_q       <= '0;
      rem_q       <= '0;
      read_q      <= 1'b0;
      pend_q      <= 1'b0;
      ack_q       <= 1'b0;
      err_q       <= 1'b0;
      cmd_ready_q <= 1'b0;
      rd_data_q   <= '0;
      rd_valid_q  <= 1'b0;
      done_q      <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      done_q     <= 1'b0;
      unique case (state_q)
        ira_pkg::ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid_i && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            busy_q      <= 1'b1;
            read_q      <= cmd_read_i;
            pend_q      <= 1'b0;
            sub_q       <= cmd_sub_i;
            rem_q       <= (cmd_len_i == ira_pkg::LEN_ZERO) ? ira_pkg::LEN_ONE : cmd_len_i;
            err_q       <= 1'b0;
            kind_q      <= ira_pkg::K_ADDR_W;
            sh_q        <= {slave_addr, ira_pkg::DIR_WRITE}; // RULE_01 RULE_05
            state_q     <= ira_pkg::ST_START;
          end
        end
        ira_pkg::ST_START: begin
          if (tick && (qtr_q == ira_pkg::QTR_LAST)) begin
            bit_q   <= ira_pkg::BIT_FIRST;
            state_q <= ira_pkg::ST_BIT;
          end
        end
        ira_pkg::ST_BIT: begin
          if (tick && (qtr_q == ira_pkg::QTR_SCL_UP)) begin
            if (bit_q != ira_pkg::ACK_SLOT) begin
              sh_q <= {sh_q[6:0], sda_s2_q}; // RULE_08
            end else begin
              ack_q <= sda_s2_q;
            end
          end
          if (tick && (qtr_q == ira_pkg::QTR_LAST)) begin
            if (bit_q != ira_pkg::ACK_SLOT) begin
              bit_q <= bit_q + ira_pkg::BIT_STEP;
            end else begin
              bit_q <= ira_pkg::BIT_FIRST;
              if (dev_nack) begin
                err_q   <= 1'b1;
                pend_q  <= 1'b0;
                state_q <= ira_pkg::ST_STOP;
              end else begin
                unique case (kind_q)
                  ira_pkg::K_ADDR_W: begin
                    kind_q <= ira_pkg::K_SUB;
                    sh_q   <= sub_q; // RULE_02 RULE_05
                  end
                  ira_pkg::K_SUB: begin
                    if (read_q) begin
                      pend_q  <= 1'b1;
                      state_q <= ira_pkg::ST_STOP; // RULE_06
                    end else begin
                      state_q <= ira_pkg::ST_FETCH;
                    end
                  end
                  ira_pkg::K_WDATA: begin
                    sub_q <= sub_q + ira_pkg::SUB_STEP; // RULE_17
                    rem_q <= rem_q - ira_pkg::LEN_ONE;
                    if (last_byte) begin
                      state_q <= need_wait ? ira_pkg::ST_WAIT : ira_pkg::ST_STOP; // RULE_04
                    end else begin
                      state_q <= ira_pkg::ST_FETCH;
                    end
                  end
                  ira_pkg::K_ADDR_R: begin
                    kind_q <= ira_pkg::K_RDATA;
                  end
                  ira_pkg::K_RDATA: begin
                    rd_data_q  <= sh_q;
                    rd_valid_q <= 1'b1;
                    sub_q      <= sub_q + ira_pkg::SUB_STEP; // RULE_17
                    rem_q      <= rem_q - ira_pkg::LEN_ONE;
                    if (last_byte) begin
                      state_q <= need_wait ? ira_pkg::ST_WAIT : ira_pkg::ST_STOP; // RULE_10
                    end
                  end
                endcase
              end
            end
          end
        end
        ira_pkg::ST_FETCH: begin
          // clock stays low while the fifo is empty, pausing the bus
          if (fif.out_valid) begin
            sh_q    <= fif.out_data;
            kind_q  <= ira_pkg::K_WDATA;
            bit_q   <= ira_pkg::BIT_FIRST;
            state_q <= ira_pkg::ST_BIT;
          end
        end
        ira_pkg::ST_WAIT: begin
          if (wait_end) begin
            state_q <= ira_pkg::ST_STOP; // RULE_13
          end
        end
        ira_pkg::ST_STOP: begin
          if (tick && (qtr_q == ira_pkg::QTR_LAST)) begin
            if (pend_q) begin
              pend_q  <= 1'b0;
              kind_q  <= ira_pkg::K_ADDR_R;
              sh_q    <= {slave_addr, ira_pkg::DIR_READ}; // RULE_07
              state_q <= ira_pkg::ST_START;
            end else begin
              state_q <= ira_pkg::ST_DONE;
            end
          end
        end
        ira_pkg::ST_DONE: begin
          done_q      <= 1'b1;
          busy_q      <= 1'b0;
          cmd_ready_q <= 1'b1;
          state_q     <= ira_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign cmd_ready_o = cmd_ready_q;
  assign wr_ready_o  = fif.in_ready;
  assign rd_data_o   = rd_data_q;
  assign rd_valid_o  = rd_valid_q;
  assign done_o      = done_q;
  assign nack_o      = err_q;
  assign busy_o      = busy_q;
  assign scl_oe_o    = scl_oe_q;
  assign sda_oe_o    = sda_oe_q;

endmodule : ira_host

// File: ira_host_assertions.sv
// port-level checks for the two-wire register access host
`timescale 1ns/1ns
module ira_host_assertions (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic cmd_valid_i,
  input  wire logic cmd_ready_o,
  input  wire logic monitor_scl_i,
  input  wire logic rd_valid_o,
  input  wire logic done_o,
  input  wire logic nack_o,
  input  wire logic busy_o,
  input  wire logic scl_i,
  input  wire logic scl_o,
  input  wire logic scl_oe_o,
  input  wire logic sda_o,
  input  wire logic sda_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_reset_bus_free: assert property ($fell(rst_i) |-> !scl_oe_o && !sda_oe_o && !cmd_ready_o)
    else $error("bus or ready not idle after reset");
  a_start_first: assert property (cmd_valid_i && cmd_ready_o |=> busy_o && !scl_oe_o && !sda_oe_o
    ##[1:400] sda_oe_o && !scl_oe_o)
    else $error("no start condition after command");
  // clock high time is two quarters, far above eight cycles
  a_clock_high_time: assert property ($fell(scl_oe_o) |-> !scl_oe_o [*8])
    else $error("clock released too briefly");
  a_pins_pull_only: assert property (!scl_o && !sda_o)
    else $error("open-drain data pin not low");
  a_done_bus_free: assert property (done_o |-> !scl_oe_o && !sda_oe_o && cmd_ready_o)
    else $error("done with bus still held");
  a_idle_released: assert property (!busy_o |-> !scl_oe_o && !sda_oe_o)
    else $error("bus pulled while idle");
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_read_in_cmd: assert property (rd_valid_o |-> busy_o && !done_o)
    else $error("read byte outside a command");
  a_stretch_held: assert property (monitor_scl_i && busy_o && !scl_oe_o && !scl_i
    |=> !scl_oe_o && $stable(sda_oe_o))
    else $error("host moved during clock stretch");
  a_nack_cleared: assert property (cmd_valid_i && cmd_ready_o |=> !nack_o)
    else $error("nack not cleared on accept");
endmodule : ira_host_assertions

bind ira_host ira_host_assertions u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .monitor_scl_i(monitor_scl_i), .rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o),
  .busy_o(busy_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o));

// File: ira_dev_model.sv
// behavioural register device on the two-wire bus, drives pulls only
`timescale 1ns/1ns
module ira_dev_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       sel_lo_i,
  input  wire logic       sel_hi_i,
  input  wire logic [7:0] stretch_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o
);
  logic [7:0] mem [256];
  logic [6:0] addr_q;
  logic [7:0] sh_q, tx_q, sub_q, hold_q;
  logic [3:0] bc_q;
  logic [1:0] ph_q;
  logic       s_q, d_q, act_q, rd_q, first_q;

  assign scl_oe_o = hold_q != 8'h00;
  // wire levels sampled on the host clock; edges found against last cycle
  always @(posedge clock_i) begin
    s_q <= scl_i;
    d_q <= sda_i;
    if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
    if (rst_i) begin
      addr_q <= {5'h17, sel_hi_i, sel_lo_i};
      // one core modelled: both routing registers start with core zero selected
      mem[8'hfe] <= 8'h01;
      mem[8'hff] <= 8'h01;
      act_q <= 1'b0;
      sda_oe_o <= 1'b0;
      hold_q <= 8'h00;
    end else if (s_q && scl_i && d_q && !sda_i) begin
      act_q <= 1'b1;
      bc_q <= 4'h0;
      ph_q <= 2'h0;
      rd_q <= 1'b0;
      first_q <= 1'b1;
    end else if (s_q && scl_i && !d_q && sda_i) begin
      act_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (act_q && !s_q && scl_i) begin
      sh_q <= {sh_q[6:0], sda_i};
      bc_q <= (bc_q == 4'h8) ? 4'h0 : bc_q + 4'h1;
      if (bc_q == 4'h8 && rd_q && sda_i) act_q <= 1'b0;
    end else if (act_q && s_q && !scl_i) begin
      first_q <= 1'b0;
      if (bc_q == 4'h8) begin
        if (rd_q) sda_oe_o <= 1'b0;
        else if (ph_q == 2'h0) begin
          if (sh_q[7:1] == addr_q) sda_oe_o <= 1'b1;
          if (sh_q[7:1] == addr_q) rd_q <= sh_q[0];
          else act_q <= 1'b0;
        end else begin
          sda_oe_o <= 1'b1;
          if (ph_q == 2'h1) sub_q <= sh_q;
          else if (mem[8'hfe][3:0] != 4'h0 || sub_q == 8'hfe) mem[sub_q] <= sh_q;
          if (ph_q == 2'h2) sub_q <= sub_q + 8'h01;
        end
      end else if (bc_q == 4'h0 && !first_q) begin
        hold_q <= stretch_i;
        ph_q <= (rd_q || ph_q == 2'h2) ? 2'h2 : ph_q + 2'h1;
        sda_oe_o <= rd_q && (mem[8'hff][3:0] != 4'h0) && !mem[sub_q][7];
        if (rd_q) tx_q <= mem[sub_q];
        if (rd_q) sub_q <= sub_q + 8'h01;
      end else if (rd_q) sda_oe_o <= !tx_q[3'(4'h7 - bc_q)];
    end
  end
endmodule : ira_dev_model

// File: ira_host_tb.sv
// self-checking bench for the two-wire register access host
`timescale 1ns/1ns
module ira_host_tb;
  localparam int WC = 50;
  logic       clock_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_read_i = 1'b0;
  logic       sel_lo = 1'b0, sel_hi = 1'b1, mon = 1'b1, wr_valid_i = 1'b0;
  logic [7:0] cmd_sub_i = 8'h00, cmd_len_i = 8'h00, wr_data_i = 8'h00, stretch = 8'h00;
  logic       cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, busy_o;
  logic       scl_o, scl_oe_o, sda_o, sda_oe_o, dev_scl_oe, dev_sda_oe;
  logic [7:0] rd_data_o;
  logic [7:0] rdq [$];
  int         n_fail = 0, cmp_count = 0, last_cyc;
  // pull-ups: a released wire reads high
  wire        scl_w = !(scl_oe_o || dev_scl_oe);
  wire        sda_w = !(sda_oe_o || dev_sda_oe);

  always #5 clock_i = ~clock_i;

  ira_host #(.WAIT_CYC(WC)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_read_i(cmd_read_i), .cmd_sub_i(cmd_sub_i), .cmd_len_i(cmd_len_i),
    .slave_addr_select_low_i(sel_lo), .slave_addr_select_high_i(sel_hi),
    .monitor_scl_i(mon), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
    .nack_o(nack_o), .busy_o(busy_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

  ira_dev_model u_dev (
    .clock_i(clock_i), .rst_i(rst_i), .sel_lo_i(sel_lo), .sel_hi_i(sel_hi),
    .stretch_i(stretch), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(dev_scl_oe),
    .sda_oe_o(dev_sda_oe));

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic push(input logic [7:0] b);
    @(posedge clock_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= b;
    @(posedge clock_i);
    wr_valid_i <= 1'b0;
  endtask : push

  task automatic run_cmd(input logic rd, input logic [7:0] sub, input logic [7:0] len);
    while (cmd_ready_o !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rd;
    cmd_sub_i <= sub;
    cmd_len_i <= len;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    last_cyc = 0;
    rdq.delete();
    do begin
      @(negedge clock_i);
      last_cyc++;
      if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
    end while (done_o !== 1'b1 && last_cyc < 60000);
    chk_flag("done", 1'b1, done_o);
  endtask : run_cmd

  task automatic t_write();
    for (int i = 0; i < 4; i++) push(8'ha0 + 8'(i));
    @(negedge clock_i);
    chk_flag("fifo full ready", 1'b0, wr_ready_o);
    push(8'hee);
    stretch <= 8'hc8;
    run_cmd(1'b0, 8'h10, 8'h04);
    chk_flag("write nack", 1'b0, nack_o);
  endtask : t_write

  // fifo runs dry mid-write: host must stall, not send stale data
  task automatic t_stall();
    @(posedge clock_i);
    mon <= 1'b0;
    stretch <= 8'h00;
    fork
      run_cmd(1'b0, 8'h14, 8'h01);
      begin
        repeat (6000) @(negedge clock_i);
        chk_flag("busy in stall", 1'b1, busy_o);
        chk_flag("clock held in stall", 1'b1, scl_oe_o);
        push(8'h77);
      end
    join
  endtask : t_stall

  task automatic t_read();
    @(posedge clock_i);
    mon <= 1'b1;
    stretch <= 8'h96;
    run_cmd(1'b1, 8'h10, 8'h05);
    chk_byte("read count", 8'h05, 8'(rdq.size()));
    for (int i = 0; i < rdq.size(); i++)
      chk_byte("read byte", (i < 4) ? 8'ha0 + 8'(i) : 8'h77, rdq[i]);
  endtask : t_read

  task automatic t_wait();
    int c90;
    @(posedge clock_i);
    mon <= 1'b0;
    stretch <= 8'h00;
    push(8'h01);
    run_cmd(1'b0, 8'h90, 8'h01);
    c90 = last_cyc;
    push(8'h02);
    run_cmd(1'b0, 8'h8f, 8'h01);
    chk_flag("wait inserted", 1'b1, (last_cyc - c90 >= WC)
      && (last_cyc - c90 <= WC + ira_pkg::QUARTER_CYC));
  endtask : t_wait

  task automatic t_stranger();
    @(posedge clock_i);
    sel_lo <= ~sel_lo;
    push(8'h03);
    run_cmd(1'b0, 8'h30, 8'h01);
    chk_flag("nack on stranger", 1'b1, nack_o);
  endtask : t_stranger

  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_write();
    t_stall();
    t_read();
    t_wait();
    t_stranger();
    wrap_up();
  end

  // whole run is near 60k cycles; cut off well past that
  initial begin
    #900000;
    n_fail++;
    wrap_up();
  end
endmodule : ira_host_tb
